// ---- common/hlt_map.svh ----
`ifndef HLT_MAP_SVH
`define HLT_MAP_SVH

// ****************************************
// Register indices on the 3-bit port.
// ****************************************
`define HLT_REG_CFG    3'h0
`define HLT_REG_IEN    3'h1
`define HLT_REG_STAT   3'h2
`define HLT_REG_UTHR   3'h3
`define HLT_REG_LTHR   3'h4
`define HLT_REG_DATA   3'h5

// ****************************************
// Field positions.
// ****************************************
`define HLT_CFG_EN     0
`define HLT_CFG_CRC    1
`define HLT_CFG_FCLR   2
`define HLT_CFG_EOM    3
`define HLT_EV_FULL    0
`define HLT_EV_LFILL   1
`define HLT_EV_OVR     2
`define HLT_EV_UDR     3
`define HLT_ST_FULL    4
`define HLT_ST_BELOW_LOW_THRESHOLD_STATUS  5

// ****************************************
// Reset values and line patterns.
// ****************************************
`define HLT_THR_RST    7'h40
`define HLT_PAT_FLAG   8'h7E
`define HLT_PAT_ABORT  8'h7F
`define HLT_PAT_IDLE   8'hFF
`define HLT_CRC_INIT   16'hFFFF
`define HLT_CRC_POLY   16'h8408
`define HLT_UNIT_BYTE  5'h08
`define HLT_UNIT_FCS   5'h10
`define HLT_STUFF_RUN  3'h5
`define HLT_FIFO_DEPTH 128

`endif

// ---- common/hlt_pkg.sv ----
package hlt_pkg;

  // One FIFO entry: payload byte and its packet marks.
  typedef struct packed {
    logic       abort;
    logic       end_of_message_bit;
    logic [7:0] data;
  } hlt_entry_t;

  // Software configuration bits.
  typedef struct packed {
    logic fclr;
    logic crc;
    logic en;
  } hlt_cfg_t;

  // Kind of unit now on the serial line.
  typedef enum logic [4:0] {
    HLT_ONES  = 5'b00001,
    HLT_FLAG  = 5'b00010,
    HLT_DATA  = 5'b00100,
    HLT_FCS   = 5'b01000,
    HLT_ABORT = 5'b10000
  } hlt_unit_t;

endpackage

// ---- design/hlt_fifo.sv ----
`timescale 1ns/1ps
`include "hlt_map.svh"

module hlt_fifo
  import hlt_pkg::*;
#(
  parameter int DEPTH = `HLT_FIFO_DEPTH,
  parameter int AW    = 7
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clr_i,
  input  wire logic          wr_i,
  input  wire hlt_entry_t    wr_entry_i,
  input  wire logic          rd_i,
  input  wire logic          mark_i,
  input  wire logic          mark_abort_i,
  output hlt_entry_t         head_o,
  output logic [AW:0]        count_o
);

  // ****************************************
  // Storage and pointers.
  // ****************************************
  if (DEPTH < 2 || DEPTH > (1 << AW))
    $error("hlt_fifo: DEPTH does not fit AW.");

  hlt_entry_t  mem_q [DEPTH];
  logic [AW-1:0] rptr_q;
  logic [AW-1:0] wptr_q;
  logic [AW:0]   count_q;

  // Pointer step with wrap at DEPTH.
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire logic do_wr = wr_i && (clr_i || count_q != (AW+1)'(DEPTH));
  wire logic do_rd = rd_i && !clr_i && count_q != '0;
  wire logic [AW-1:0] wr_at   = clr_i ? '0 : wptr_q;
  wire logic [AW-1:0] last_at = (wptr_q == '0) ? AW'(DEPTH - 1)
                                               : wptr_q - 1'b1;

  assign head_o  = mem_q[rptr_q];
  assign count_o = count_q;

  // Each entry takes a write or a mark of the last written byte.
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mem_q[i] <= '0;
      end else if (do_wr && wr_at == AW'(i)) begin
        mem_q[i] <= wr_entry_i;
      end else if (mark_i && last_at == AW'(i)) begin
        mem_q[i].end_of_message_bit   <= 1'b1;
        mem_q[i].abort <= mark_abort_i;
      end
    end
  end

  // Pointers; a clear may coincide with a write into slot zero.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rptr_q  <= '0;
      wptr_q  <= '0;
      count_q <= '0;
    end else if (clr_i) begin
      rptr_q  <= '0;
      wptr_q  <= do_wr ? AW'(1) : '0;
      count_q <= do_wr ? (AW+1)'(1) : '0;
    end else begin
      if (do_wr) wptr_q <= step(wptr_q);
      if (do_rd) rptr_q <= step(rptr_q);
      count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule

// ---- design/hlt_tx.sv ----
`timescale 1ns/1ps
`include "hlt_map.svh"


module hlt_tx
  import hlt_pkg::*;
#(
  parameter int DEPTH = `HLT_FIFO_DEPTH,
  parameter int AW    = 7
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rd_data_o,
  input  wire logic       link_req_i,
  output logic            link_data_o,
  output logic            irq_out_n_o
);

  if (AW != 7)
    $error("hlt_tx: thresholds are seven bits wide.");

  // ****************************************
  // Register state.
  // ****************************************
  hlt_cfg_t   cfg_q;
  logic [3:0] ien_q;
  logic [3:0] ev_q;
  logic [6:0] uthr_q;
  logic [6:0] lthr_q;
  logic [7:0] rd_data_q;
  logic       irq_n_q;
  logic       udr_hold_q;
  logic       ovr_hold_q;
  logic       discard_q;
  logic       wr_in_pkt_q;
  logic       full_d1_q;
  logic       below_d1_q;
  logic [AW:0] pkt_cnt_q;

  // ****************************************
  // Serializer state.
  // ****************************************
  hlt_unit_t   unit_q;
  logic [15:0] sh_q;
  logic [4:0]  left_q;
  logic [2:0]  ones_q;
  logic        stf_q;
  logic        crc_on_q;
  logic [15:0] crc_q;
  logic        in_pkt_q;
  logic        fcs_pend_q;
  logic        abort_pend_q;
  logic        need_flag_q;
  logic        link_q;

  // Reflected CRC-16 step for one serial bit.
  function automatic logic [15:0] crc_bit(input logic [15:0] c,
                                          input logic b);
    crc_bit = (c >> 1) ^ ((c[0] ^ b) ? `HLT_CRC_POLY : 16'h0000);
  endfunction

  // Register select shared by the write and read paths.
  function automatic logic sel(input logic [2:0] a,
                               input logic [2:0] r);
    sel = (a == r);
  endfunction

  // ****************************************
  // FIFO and its status.
  // ****************************************
  hlt_entry_t  head;
  logic [AW:0] count;
  wire logic full  = (count == (AW+1)'(DEPTH));
  wire logic below = (count < {1'b0, lthr_q});
  wire logic empty = (count == '0);

  // Host side decode.
  wire logic cfg_wr  = wr_i && sel(addr_i, `HLT_REG_CFG);
  wire logic ien_wr  = wr_i && sel(addr_i, `HLT_REG_IEN);
  wire logic stat_wr = wr_i && sel(addr_i, `HLT_REG_STAT);
  wire logic uthr_wr = wr_i && sel(addr_i, `HLT_REG_UTHR);
  wire logic lthr_wr = wr_i && sel(addr_i, `HLT_REG_LTHR);
  wire logic dat_wr  = wr_i && sel(addr_i, `HLT_REG_DATA);
  wire logic stat_rd = rd_i && sel(addr_i, `HLT_REG_STAT);
  wire logic eom_req = cfg_wr && wr_data_i[`HLT_CFG_EOM];

  // Overflow: the sending packet, or one still being written.
  wire logic ovf    = dat_wr && full && !udr_hold_q && !discard_q;
  wire logic ovf_tx = ovf && in_pkt_q && pkt_cnt_q == '0;
  wire logic ovf_ot = ovf && !ovf_tx;

  // FIFO control; a held clear keeps the FIFO in reset.
  wire logic fifo_clr = cfg_q.fclr || udr_hold_q
                        || ovr_hold_q || ovf_tx;
  wire logic fifo_wr  = dat_wr && !full && !discard_q
                        && !udr_hold_q;
  wire logic mark_eom = eom_req && wr_in_pkt_q && !discard_q
                        && !udr_hold_q;
  wire logic mark_ovr = ovf_ot && wr_in_pkt_q;
  wire hlt_entry_t wr_entry = '{abort: 1'b0, end_of_message_bit: 1'b0,
                                data: wr_data_i};

  // ****************************************
  // Unit selection at a byte boundary.
  // ****************************************
  wire logic stuff_due = stf_q && ones_q == `HLT_STUFF_RUN;
  wire logic load      = left_q == '0 && !stuff_due && !link_req_i;
  wire logic start     = !empty && (pkt_cnt_q != '0
                         || count > {1'b0, uthr_q});
  wire logic abort_now = abort_pend_q || ovf_tx;
  wire logic take      = cfg_q.en && !abort_now && !fcs_pend_q
                         && !need_flag_q && (in_pkt_q || start);
  wire logic udr_now   = load && take && in_pkt_q && empty;
  wire logic pop       = load && take && !empty && !fifo_clr;
  wire logic pop_eom   = pop && head.end_of_message_bit;

  hlt_fifo #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .clr_i        (fifo_clr),
    .wr_i         (fifo_wr),
    .wr_entry_i   (wr_entry),
    .rd_i         (pop),
    .mark_i       (mark_eom || mark_ovr),
    .mark_abort_i (mark_ovr),
    .head_o       (head),
    .count_o      (count)
  );

  // ****************************************
  // Read data and interrupt.
  // ****************************************
  wire logic [7:0] stat_val = {2'b00, below, full, ev_q};
  wire logic [7:0] rd_mux =
    sel(addr_i, `HLT_REG_CFG)  ? {5'h00, cfg_q.fclr, cfg_q.crc,
                                  cfg_q.en} :
    sel(addr_i, `HLT_REG_IEN)  ? {4'h0, ien_q} :
    sel(addr_i, `HLT_REG_STAT) ? stat_val :
    sel(addr_i, `HLT_REG_UTHR) ? {1'b0, uthr_q} :
    sel(addr_i, `HLT_REG_LTHR) ? {1'b0, lthr_q} : 8'h00;

  // New events this cycle, in event-bit order.
  wire logic [3:0] ev_set;
  assign ev_set[`HLT_EV_FULL]  = full && !full_d1_q;
  assign ev_set[`HLT_EV_LFILL] = below && !below_d1_q;
  assign ev_set[`HLT_EV_OVR]   = ovf;
  assign ev_set[`HLT_EV_UDR]   = udr_now;

  // Configuration, enables and thresholds.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q  <= '0;
      ien_q  <= '0;
      uthr_q <= `HLT_THR_RST;
      lthr_q <= `HLT_THR_RST;
    end else begin
      if (cfg_wr) begin
        cfg_q.en   <= wr_data_i[`HLT_CFG_EN];
        cfg_q.crc  <= wr_data_i[`HLT_CFG_CRC];
        cfg_q.fclr <= wr_data_i[`HLT_CFG_FCLR];
      end
      if (ien_wr)  ien_q  <= wr_data_i[3:0];
      if (uthr_wr) uthr_q <= wr_data_i[6:0];
      if (lthr_wr) lthr_q <= wr_data_i[6:0];
    end
  end

  // Latched events: a new event wins over the read clear.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ev_q       <= '0;
      full_d1_q  <= 1'b0;
      below_d1_q <= 1'b1;
      rd_data_q  <= '0;
      irq_n_q    <= 1'b1;
    end else begin
      ev_q       <= (stat_rd ? 4'h0 : ev_q) | ev_set;
      full_d1_q  <= full;
      below_d1_q <= below;
      rd_data_q  <= rd_i ? rd_mux : 8'h00;
      irq_n_q    <= ~|(ev_q & ien_q);
    end
  end

  // Underrun and overflow holds on the FIFO.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      udr_hold_q <= 1'b0;
      ovr_hold_q <= 1'b0;
    end else begin
      if (udr_now)
        udr_hold_q <= 1'b1;
      else if (stat_wr)
        udr_hold_q <= 1'b0;
      if (ovf_tx)
        ovr_hold_q <= 1'b1;
      else if (dat_wr)
        ovr_hold_q <= 1'b0;
    end
  end

  // Packet bookkeeping on the write side.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      discard_q   <= 1'b0;
      wr_in_pkt_q <= 1'b0;
      pkt_cnt_q   <= '0;
    end else begin
      if (ovf_ot)
        discard_q <= 1'b1;
      else if (eom_req || fifo_clr)
        discard_q <= 1'b0;
      if (fifo_wr)
        wr_in_pkt_q <= 1'b1;
      else if (fifo_clr || mark_eom || mark_ovr)
        wr_in_pkt_q <= 1'b0;
      if (fifo_clr)
        pkt_cnt_q <= '0;
      else
        pkt_cnt_q <= pkt_cnt_q
                     + (AW+1)'(mark_eom || mark_ovr)
                     - (AW+1)'(pop_eom);
    end
  end

  // ****************************************
  // Serializer: one bit per link request.
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_q <= 1'b1;
      sh_q   <= '0;
      left_q <= '0;
      ones_q <= '0;
    end else if (link_req_i && stuff_due) begin
      link_q <= 1'b0;
      ones_q <= '0;
    end else if (link_req_i && left_q != '0) begin
      link_q <= sh_q[0];
      sh_q   <= sh_q >> 1;
      left_q <= left_q - 1'b1;
      ones_q <= (stf_q && sh_q[0]) ? ones_q + 1'b1 : '0;
    end else if (load) begin
      left_q <= (cfg_q.en && !abort_now && fcs_pend_q) ?
                `HLT_UNIT_FCS : `HLT_UNIT_BYTE;
      if (!cfg_q.en)
        sh_q <= {8'h00, `HLT_PAT_IDLE};
      else if (abort_now || udr_now || (pop && head.abort))
        sh_q <= {8'h00, `HLT_PAT_ABORT};
      else if (fcs_pend_q)
        sh_q <= ~crc_q;
      else if (pop)
        sh_q <= {8'h00, head.data};
      else
        sh_q <= {8'h00, `HLT_PAT_FLAG};
    end
  end

  // Unit kind, packet state and running CRC.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unit_q       <= HLT_ONES;
      stf_q        <= 1'b0;
      crc_on_q     <= 1'b0;
      crc_q        <= `HLT_CRC_INIT;
      in_pkt_q     <= 1'b0;
      fcs_pend_q   <= 1'b0;
      abort_pend_q <= 1'b0;
      need_flag_q  <= 1'b1;
    end else if (load && !link_req_i) begin
      stf_q    <= 1'b0;
      crc_on_q <= 1'b0;
      if (!cfg_q.en) begin
        unit_q      <= HLT_ONES;
        in_pkt_q    <= 1'b0;
        fcs_pend_q  <= 1'b0;
        need_flag_q <= 1'b1;
      end else if (abort_now || udr_now || (pop && head.abort)) begin
        unit_q       <= HLT_ABORT;
        abort_pend_q <= 1'b0;
        in_pkt_q     <= 1'b0;
        fcs_pend_q   <= 1'b0;
        need_flag_q  <= 1'b1;
      end else if (fcs_pend_q) begin
        unit_q      <= HLT_FCS;
        stf_q       <= 1'b1;
        fcs_pend_q  <= 1'b0;
        need_flag_q <= 1'b1;
      end else if (pop) begin
        unit_q   <= HLT_DATA;
        stf_q    <= 1'b1;
        crc_on_q <= 1'b1;
        if (!in_pkt_q)
          crc_q <= `HLT_CRC_INIT;
        in_pkt_q    <= !head.end_of_message_bit;
        fcs_pend_q  <= head.end_of_message_bit && cfg_q.crc;
        need_flag_q <= head.end_of_message_bit;
      end else begin
        unit_q      <= HLT_FLAG;
        need_flag_q <= 1'b0;
      end
    end else begin
      if (ovf_tx)
        abort_pend_q <= 1'b1;
      if (ovf_tx)
        in_pkt_q <= 1'b0;
      if (link_req_i && !stuff_due && left_q != '0 && crc_on_q)
        crc_q <= crc_bit(crc_q, sh_q[0]);
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  assign rd_data_o   = rd_data_q;
  assign link_data_o = link_q;
  assign irq_out_n_o = irq_n_q;

endmodule

// ---- testbench/hlt_tx_checker.sv ----
`timescale 1ns/1ps
`include "hlt_map.svh"

// ****************************************
// Port checker for the link transmitter.
// ****************************************
module hlt_tx_checker
  import hlt_pkg::*;
#(
  parameter int DEPTH = `HLT_FIFO_DEPTH
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       link_req_i,
  input wire logic       link_data_o,
  input wire logic       irq_out_n_o
);
  logic       en_q;
  logic       run_q;
  logic [3:0] ien_q;
  logic [6:0] lo_q;
  logic [8:0] cnt_q;

  // Decoded register strobes.
  wire wr_cfg  = wr_i && addr_i == `HLT_REG_CFG;
  wire wr_ien  = wr_i && addr_i == `HLT_REG_IEN;
  wire wr_dat  = wr_i && addr_i == `HLT_REG_DATA;
  wire rd_stat = rd_i && addr_i == `HLT_REG_STAT;

  // Shadow settings, and the fill level while nothing has drained yet.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q  <= 1'b0;
      run_q <= 1'b0;
      ien_q <= 4'h0;
      lo_q  <= `HLT_THR_RST;
      cnt_q <= 9'h000;
    end else begin
      if (wr_cfg) en_q <= wr_data_i[`HLT_CFG_EN];
      if (wr_cfg && wr_data_i[`HLT_CFG_EN]) run_q <= 1'b1;
      if (wr_ien) ien_q <= wr_data_i[3:0];
      if (wr_i && addr_i == `HLT_REG_LTHR) lo_q <= wr_data_i[6:0];
      if (wr_cfg && wr_data_i[`HLT_CFG_FCLR]) cnt_q <= 9'h000;
      else if (wr_dat && cnt_q < 9'(DEPTH)) cnt_q <= cnt_q + 9'h001;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_req;
    link_req_i;
  endsequence

  property p_idle;
    s_req ##0 !en_q |=> link_data_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("link not idle while disabled");

  property p_hold;
    !link_req_i |=> $stable(link_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("link bit moved without a request");

  property p_rd_quiet;
    !rd_i |=> rd_data_o == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside its cycle");

  property p_irq_off;
    ien_q == 4'h0 && $past(ien_q) == 4'h0 |-> irq_out_n_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables clear");

  property p_irq_fall;
    $fell(irq_out_n_o) |-> $past(ien_q) != 4'h0;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell with no enable");

  property p_irq_rise;
    $rose(irq_out_n_o) |-> $past(rd_stat) || $past(rd_stat, 2) ||
      $past(wr_ien) || $past(wr_ien, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt released without a status read");

  property p_full;
    rd_stat && !run_q |=> rd_data_o[`HLT_ST_FULL] == (cnt_q == 9'(DEPTH));
  endproperty
  a_full: assert property (p_full)
    else $error("full bit wrong");

  property p_low;
    rd_stat && !run_q |=> rd_data_o[`HLT_ST_BELOW_LOW_THRESHOLD_STATUS] == (cnt_q < {2'b0, lo_q});
  endproperty
  a_low: assert property (p_low)
    else $error("below threshold bit wrong");
endmodule

bind hlt_tx hlt_tx_checker #(.DEPTH(DEPTH)) hlt_tx_checker_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .link_req_i(link_req_i),
  .link_data_o(link_data_o), .irq_out_n_o(irq_out_n_o));

// ---- testbench/hlt_link_model.sv ----
`timescale 1ns/1ps

// ****************************************
// Framer side: asks for one bit every GAP clocks.
// ****************************************
module hlt_link_model #(
  parameter int GAP = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic link_data_i,
  output logic      link_req_o,
  output logic      bit_o,
  output logic      bit_stb_o
);
  int   tick_q;
  logic ask_q;

  // Pulse a request, then take the answer one clock after it is served.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_q     <= 0;
      link_req_o <= 1'b0;
      ask_q      <= 1'b0;
      bit_stb_o  <= 1'b0;
      bit_o      <= 1'b1;
    end else begin
      tick_q     <= (tick_q == GAP - 1) ? 0 : tick_q + 1;
      link_req_o <= (tick_q == GAP - 1);
      ask_q      <= link_req_o;
      bit_stb_o  <= ask_q;
      bit_o      <= link_data_i;
    end
  end
endmodule

// ---- testbench/tb_hlt_tx.sv ----
`timescale 1ns/1ps
`include "hlt_map.svh"

module tb_hlt_tx;
  logic       clk_i     = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [2:0] addr_i    = 3'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic [7:0] rd_data_o;
  logic       link_req_i;
  logic       link_data_o;
  logic       irq_out_n_o;
  logic       bit_o;
  logic       bit_stb_o;
  logic [7:0] by;
  logic       fb[$];
  logic [7:0] rxq[$];
  int n_mismatch = 0;
  int n_checks   = 0;
  int n_cyc      = 0;
  int ones       = 0;
  int n_flag     = 0;
  int n_abort    = 0;
  int n_zero     = 0;

  // 25 MHz clock.
  always #20 clk_i = ~clk_i;

  hlt_tx #(.DEPTH(`HLT_FIFO_DEPTH), .AW(7)) hlt_tx_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .link_req_i(link_req_i),
    .link_data_o(link_data_o), .irq_out_n_o(irq_out_n_o));

  hlt_link_model #(.GAP(4)) hlt_link_model_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_data_i(link_data_o),
    .link_req_o(link_req_i), .bit_o(bit_o), .bit_stb_o(bit_stb_o));

  // Undo zero stuffing, count flags and aborts, cut frames into bytes.
  always @(posedge clk_i) begin
    if (bit_stb_o === 1'b1 && bit_o === 1'b1) begin
      ones++;
      if (ones < 7) fb.push_back(1'b1);
      if (ones == 7) begin
        n_abort++;
        fb.delete();
      end
    end else if (bit_stb_o === 1'b1) begin
      n_zero++;
      if (ones == 6) begin
        n_flag++;
        for (int i = 0; i + 15 <= fb.size(); i += 8) begin
          for (int j = 0; j < 8; j++) by[j] = fb[i + j];
          rxq.push_back(by);
        end
        fb.delete();
      end else if (ones != 5) fb.push_back(1'b0);
      ones = 0;
    end
  end

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles, spaced nine clocks apart.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (7) @(posedge clk_i);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    d = rd_data_o;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic st(input logic [7:0] exp);
    logic [7:0] s;
    rd(`HLT_REG_STAT, s);
    check(s & 8'h3F, exp);
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 3000 && rxq.size() < n; i++) @(posedge clk_i);
  endtask

  // Polled host: write once full is clear or below is set, or after 50 status reads.
  task automatic poll_wr(input logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    s[`HLT_ST_FULL] = 1'b1;
    for (int i = 0; i < 50 && s[`HLT_ST_FULL] && !s[`HLT_ST_BELOW_LOW_THRESHOLD_STATUS]; i++)
      rd(`HLT_REG_STAT, s);
    wr(`HLT_REG_DATA, d);
  endtask

  function automatic logic [15:0] fcs(input logic [15:0] dat);
    logic [15:0] c;
    c = `HLT_CRC_INIT;
    for (int i = 0; i < 16; i++)
      c = (c[0] ^ dat[i]) ? (c >> 1) ^ `HLT_CRC_POLY : c >> 1;
    return ~c;
  endfunction

  task automatic t_idle();
    repeat (80) @(posedge clk_i);
    check(8'(n_zero), 8'h00);
  endtask

  // Fill while disabled: status bits, overflow and interrupt gating.
  task automatic t_fill();
    logic [7:0] s;
    wr(`HLT_REG_LTHR, 8'h02);
    wr(`HLT_REG_CFG, 8'h04);
    wr(`HLT_REG_CFG, 8'h00);
    rd(`HLT_REG_STAT, s);
    st(8'h20);
    repeat (3) wr(`HLT_REG_DATA, 8'h41);
    st(8'h00);
    repeat (124) wr(`HLT_REG_DATA, 8'h41);
    st(8'h00);
    wr(`HLT_REG_DATA, 8'h41);
    st(8'h11);
    st(8'h10);
    wr(`HLT_REG_DATA, 8'h41);
    st(8'h14);
    wr(`HLT_REG_IEN, 8'h04);
    wr(`HLT_REG_CFG, 8'h08);
    wr(`HLT_REG_DATA, 8'h41);
    check({7'h00, irq_out_n_o}, 8'h00);
    st(8'h14);
    check({7'h00, irq_out_n_o}, 8'h01);
    wr(`HLT_REG_IEN, 8'h00);
    wr(`HLT_REG_CFG, 8'h04);
    wr(`HLT_REG_CFG, 8'h00);
    st(8'h22);
  endtask

  // Flags when empty, then one packet with and one without FCS.
  task automatic t_pkt();
    int f0;
    logic [15:0] fc;
    f0 = n_flag;
    fc = fcs(16'h2241);
    wr(`HLT_REG_CFG, 8'h03);
    repeat (200) @(posedge clk_i);
    check(8'(n_flag - f0 > 2), 8'h01);
    for (int c = 1; c >= 0; c--) begin
      rxq.delete();
      wr(`HLT_REG_CFG, 8'h01 | 8'(c << 1));
      wr(`HLT_REG_DATA, 8'h41);
      wr(`HLT_REG_DATA, 8'h22);
      wr(`HLT_REG_CFG, 8'h09 | 8'(c << 1));
      wait_rx(2 + 2 * c);
      f0 = n_flag;
      repeat (150) @(posedge clk_i);
      check(8'(rxq.size()), 8'(2 + 2 * c));
      check(rxq[0], 8'h41);
      check(rxq[1], 8'h22);
      if (c == 1) check(rxq[2], fc[7:0]);
      if (c == 1) check(rxq[3], fc[15:8]);
      check(8'(n_flag > f0), 8'h01);
    end
  endtask

  // Threshold start without end mark runs dry, then release.
  task automatic t_under();
    int a0;
    a0 = n_abort;
    wr(`HLT_REG_UTHR, 8'h02);
    repeat (3) wr(`HLT_REG_DATA, 8'h41);
    repeat (600) @(posedge clk_i);
    st(8'h2A);
    check(8'(n_abort - a0), 8'h01);
    wr(`HLT_REG_DATA, 8'h55);
    wr(`HLT_REG_STAT, 8'h00);
    wr(`HLT_REG_UTHR, 8'h40);
    rxq.delete();
    poll_wr(8'h22);
    wr(`HLT_REG_CFG, 8'h09);
    wait_rx(1);
    repeat (100) @(posedge clk_i);
    check(8'(rxq.size()), 8'h01);
    check(rxq[0], 8'h22);
  endtask

  // The packet on the line outgrows the buffer.
  task automatic t_ovr();
    int a0;
    logic [7:0] s;
    a0 = n_abort;
    wr(`HLT_REG_UTHR, 8'h00);
    wr(`HLT_REG_IEN, 8'h04);
    for (int i = 0; i < 300 && irq_out_n_o !== 1'b0; i++)
      wr(`HLT_REG_DATA, 8'h41);
    rd(`HLT_REG_STAT, s);
    check(s & 8'h04, 8'h04);
    check({7'h00, irq_out_n_o}, 8'h01);
    repeat (100) @(posedge clk_i);
    check(8'(n_abort > a0), 8'h01);
    wr(`HLT_REG_UTHR, 8'h40);
    rxq.delete();
    poll_wr(8'h33);
    wr(`HLT_REG_CFG, 8'h09);
    wait_rx(1);
    repeat (100) @(posedge clk_i);
    check(8'(rxq.size()), 8'h01);
    check(rxq[0], 8'h33);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_idle();
    t_fill();
    t_pkt();
    t_under();
    t_ovr();
    stop_test();
  end
endmodule
